// File: design/sbc_ctl.sv
// Purpose: Memory controller issuing bursts to the SRAM from Avalon-MM
// Assumes: One clock shared with the device
// Notes:   Answers every bus access on the second edge
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_ctl
    import sbc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    sbc_if.ctl               pins,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    // Whole controller state in one record
    typedef struct packed {
        sbc_ctl_state_t      st;      // Sequencer state
        logic [1:0]          ctrl;    // Sleep and order control
        logic [`SBC_AW-1:0]  base;    // Burst start address
        logic [31:0]         wdata;   // Write bytes, beat 0 lowest
        logic [31:0]         rdata;   // Read bytes, beat 0 lowest
        logic                cmd_wr;  // Command is a write
        logic [1:0]          cmd_len; // Beats minus one
        logic                pend;    // Command accepted, cleared in drain
        logic [1:0]          beat;    // Beat on the pins now
        logic                rd_v;    // Read data due this edge
        logic [1:0]          rd_beat; // Beat of that read data
        logic                ack;     // Bus answer given
        logic [31:0]         rdreg;   // Bus read data
        logic                sleep_o; // Sleep pin level
        logic [1:0]          rec_cnt; // Recovery cycles left
        logic                load_advance_ctl;     // Pin registers from here
        logic                ce_n;
        logic                we_n;
        logic [`SBC_AW-1:0]  addr;
        logic [`SBC_DW-1:0]  dq_o;
        logic                dq_oe;
    } sbc_ctl_state_t2;

    sbc_ctl_state_t2 s_q;   // Registered state
    sbc_ctl_state_t2 s_d;   // Next state
    logic            req;   // Bus request present
    logic            busy;  // Command in flight
    logic [2:0]      widx;  // Decoded word index

    assign req  = avs_read | avs_write;
    assign busy = s_q.pend | (s_q.st != SBC_ST_IDLE);
    assign widx = avs_address[4:2];

    // Next state
    always_comb begin
        s_d       = s_q;
        s_d.ack   = req & ~s_q.ack;
        s_d.rd_v  = 1'b0;
        s_d.dq_oe = 1'b0;
        // Capture read data one edge after its address edge
        if (s_q.rd_v) begin
            s_d.rdata[s_q.rd_beat*8 +: 8] = pins.dq;
        end
        // Bus slave, acts on the first edge of a request
        if (req && !s_q.ack) begin
            if (avs_write) begin
                unique case (widx)
                    `SBC_OFF_CTRL:  s_d.ctrl  = avs_writedata[1:0];
                    `SBC_OFF_ADDR:  s_d.base  = avs_writedata[`SBC_AW-1:0];
                    `SBC_OFF_WDATA: s_d.wdata = avs_writedata;
                    `SBC_OFF_CMD: begin
                        // Ignored while busy
                        if (!busy) begin
                            s_d.cmd_wr  = avs_writedata[`SBC_CMD_WRITE];
                            s_d.cmd_len = avs_writedata[`SBC_CMD_LEN_LO +: 2];
                            s_d.pend    = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else begin
                unique case (widx)
                    `SBC_OFF_CTRL:   s_d.rdreg = {30'h0, s_q.ctrl};
                    `SBC_OFF_ADDR:   s_d.rdreg = {26'h0, s_q.base};
                    `SBC_OFF_WDATA:  s_d.rdreg = s_q.wdata;
                    `SBC_OFF_CMD:    s_d.rdreg = {29'h0, s_q.cmd_len, s_q.cmd_wr};
                    `SBC_OFF_RDATA:  s_d.rdreg = s_q.rdata;
                    `SBC_OFF_STATUS: s_d.rdreg = {29'h0, s_q.rec_cnt != 2'd0,
                                                  s_q.sleep_o, busy};
                    default:         s_d.rdreg = `SBC_WORD_RST;
                endcase
            end
        end
        // Sleep only when nothing is pending or in flight [R13]
        if (s_q.ctrl[`SBC_CTRL_SLEEP] && !busy && s_q.rec_cnt == 2'd0) begin
            s_d.sleep_o = 1'b1;
        end else if (!s_q.ctrl[`SBC_CTRL_SLEEP] && s_q.sleep_o) begin
            s_d.sleep_o = 1'b0;
            s_d.rec_cnt = `SBC_SLEEP_RECOV_CYC;
        end else if (s_q.rec_cnt != 2'd0) begin
            s_d.rec_cnt = s_q.rec_cnt - 2'd1;
        end
        // Sequencer
        unique case (s_q.st)
            SBC_ST_IDLE: begin
                // Nothing but deselects during sleep and recovery [R14]
                if (s_q.pend && !s_q.sleep_o && !s_q.ctrl[`SBC_CTRL_SLEEP]
                    && s_q.rec_cnt == 2'd0) begin
                    s_d.ce_n = 1'b0;
                    s_d.load_advance_ctl  = 1'b0;                    // [R2]
                    s_d.we_n = ~s_q.cmd_wr;
                    s_d.addr = s_q.base;
                    s_d.beat = 2'd0;
                    s_d.st   = SBC_ST_ISSUE;
                end
            end
            SBC_ST_ISSUE: begin
                // Data phase of the beat the device just took
                if (s_q.cmd_wr) begin
                    s_d.dq_o  = s_q.wdata[s_q.beat*8 +: 8];
                    s_d.dq_oe = 1'b1;
                end else begin
                    s_d.rd_v    = 1'b1;
                    s_d.rd_beat = s_q.beat;
                end
                if (s_q.beat == s_q.cmd_len) begin
                    s_d.ce_n = 1'b1;
                    s_d.load_advance_ctl  = 1'b0;
                    s_d.st   = SBC_ST_DRAIN;
                end else begin
                    s_d.load_advance_ctl  = 1'b1;                    // [R1]
                    s_d.beat = s_q.beat + 2'd1;
                end
            end
            SBC_ST_DRAIN: begin
                s_d.pend = 1'b0;
                s_d.st   = SBC_ST_IDLE;
            end
            default: s_d.st = SBC_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q      <= '0;
            s_q.ce_n <= 1'b1;
            s_q.we_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest      = req & ~s_q.ack;
    assign avs_readdata         = s_q.rdreg;
    assign pins.addr            = s_q.addr;
    assign pins.load_advance_ctl             = s_q.load_advance_ctl;
    assign pins.ce_n            = s_q.ce_n;
    assign pins.we_n            = s_q.we_n;
    assign pins.bw_n            = 1'b0;
    assign pins.oe_n            = 1'b0;
    assign pins.burst_order_sel = s_q.ctrl[`SBC_CTRL_ORDER]; // [R18]
    assign pins.sleep_req_o     = s_q.sleep_o;
    assign pins.sleep_req_oe    = 1'b1;
    assign pins.ctl_dq_o        = s_q.dq_o;
    assign pins.ctl_dq_oe       = s_q.dq_oe;

endmodule

// File: design/sbc_defines.svh
// Purpose: Shared constants for the burst SRAM device and its controller
// Assumes: Included by bare name; definitions only
// Notes:   Register offsets are word indices, avs_address[4:2] on the Avalon-MM slave
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH
`define SBC_AW              6
`define SBC_DW              8
`define SBC_DEPTH           64
`define SBC_SLEEP_ENTRY_CYC 2
`define SBC_SLEEP_RECOV_CYC 2'd2
`define SBC_OFF_CTRL        3'h0
`define SBC_OFF_ADDR        3'h1
`define SBC_OFF_WDATA       3'h2
`define SBC_OFF_CMD         3'h3
`define SBC_OFF_RDATA       3'h4
`define SBC_OFF_STATUS      3'h5
`define SBC_CTRL_SLEEP      0
`define SBC_CTRL_ORDER      1
`define SBC_CMD_WRITE       0
`define SBC_CMD_LEN_LO      1
`define SBC_ST_BUSY         0
`define SBC_ST_SLEEP        1
`define SBC_ST_RECOV        2
`define SBC_CTRL_RST        2'h0
`define SBC_WORD_RST        32'h0000_0000
`endif

// File: design/sbc_pkg.sv
// Purpose: Types shared by both ends of the burst SRAM link
// Assumes: Constants come from sbc_defines.svh
// Notes:   Operation codes are kept by the device across a burst
package sbc_pkg;
    typedef enum logic [1:0] {
        SBC_OP_NONE  = 2'b00,
        SBC_OP_READ  = 2'b01,
        SBC_OP_WRITE = 2'b10
    } sbc_op_t;
    typedef enum logic [1:0] {
        SBC_ST_IDLE  = 2'b00,
        SBC_ST_ISSUE = 2'b01,
        SBC_ST_DRAIN = 2'b10
    } sbc_ctl_state_t;
endpackage

// File: design/sbc_if.sv
// Purpose: Pin bundle between the burst SRAM device and its controller
// Assumes: Both ends run on the same clock, supplied by the bench
// Notes:   Data bus and sleep pin are resolved here from the enables
`timescale 1ns/1ps
`include "sbc_defines.svh"
interface sbc_if;
    logic [`SBC_AW-1:0] addr;            // External address
    logic               load_advance_ctl;             // load_advance_ctl, low loads
    logic               ce_n;            // Chip enable, active low
    logic               we_n;            // Write enable, active low
    logic               bw_n;            // Byte write, active low
    logic               oe_n;            // Output enable, active low
    logic               burst_order_sel; // High selects interleaved
    logic               sleep_req_o;     // Sleep level from controller
    logic               sleep_req_oe;    // Controller drives sleep pin
    logic               sleep_req;       // Resolved sleep pin
    logic [`SBC_DW-1:0] ctl_dq_o;        // Controller data out
    logic               ctl_dq_oe;       // Controller drives data
    logic [`SBC_DW-1:0] dev_dq_o;        // Device data out
    logic               dev_dq_oe;       // Device drives data
    logic [`SBC_DW-1:0] dq;              // Resolved data bus

    // Pull-down: an undriven sleep pin reads low
    assign sleep_req = sleep_req_oe & sleep_req_o;
    // Undriven bus reads zero
    assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : {`SBC_DW{1'b0}});

    modport dev (input addr, load_advance_ctl, ce_n, we_n, bw_n, oe_n, burst_order_sel,
                 input sleep_req, dq, output dev_dq_o, dev_dq_oe);
    modport ctl (output addr, load_advance_ctl, ce_n, we_n, bw_n, oe_n, burst_order_sel,
                 output sleep_req_o, sleep_req_oe, ctl_dq_o, ctl_dq_oe,
                 input dq);
endinterface

// File: design/sbc_dev.sv
// Purpose: Flow-through single-late-write SRAM with burst counter and sleep
// Assumes: Synchronous inputs meet setup to core_clk; sleep pin may be async
// Notes:   Small array stands in for the memory core
//   Late write: data one edge after its address
//   Read data stands the cycle after its address
//   No clock enable, no depth-expansion enables
//   Deselect closes an open burst
// Notes on behaviour
// [R1] Load/advance high steps counter, uses it
// [R2] Load/advance low captures new burst start
// [R3] Counter wraps after four accesses
// [R4] Order low: low bits count up modulo four
// [R5] Order high: low bits XOR access index
// [R6] Sleep pin pulled down, low means active
// [R7] Sleep is async, lasts while pin high
// [R8] Sleep entered two cycles after rise
// [R9] Sleep keeps all internal state
// [R10] Normal operation two cycles after fall
// [R11] Asleep: inputs ignored, outputs released
// [R12] Asleep: deselected, no accesses
// [R13] Controller sleeps only when idle
// [R14] Recovery: only deselect or read
// [R15] Burst counter is two bits, low address
// [R16] Low address bits preload the counter
// [R17] Counter steps on every continue cycle
// [R18] Burst order is static configuration
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_dev
    import sbc_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    sbc_if.dev                       pins,
    output logic                     dev_sleeping,
    output logic [`SBC_AW-1:0]       dev_access_addr,
    output logic                     dev_access_vld
);

    // Whole device state in one record
    // Trade-off: reset also clears the array
    typedef struct packed {
        logic [`SBC_SLEEP_ENTRY_CYC-1:0]       sync;     // Sleep synchroniser

        logic [`SBC_AW-1:0]                    base;     // Loaded start address

        logic [1:0]                            idx;      // Burst access index

        sbc_op_t                               op;       // Operation of burst

        logic                                  wr_pend;  // Late write pending

        logic [`SBC_AW-1:0]                    wr_addr;  // Late write target

        logic [`SBC_DW-1:0]                    dq_o;     // Read data register

        logic                                  dq_oe;    // Read data valid

        logic [`SBC_AW-1:0]                    acc_addr; // Last access address

        logic                                  acc_vld;  // Access this edge

        logic [`SBC_DEPTH-1:0][`SBC_DW-1:0]    mem;      // Storage array
    } sbc_dev_state_t;

    // Only the clocked process writes s_q
    sbc_dev_state_t s_q;      // Registered state
    sbc_dev_state_t s_d;      // Next state

    // Helpers, all but asleep set at the top of the process
    logic                asleep;   // Synchronised sleep level

    logic [1:0]          nxt_idx;  // Index of a continue access

    logic [1:0]          low_bits; // Generated low address bits

    logic [`SBC_AW-1:0]  acc;      // Address used this edge

    logic                do_acc;   // An access happens this edge

    // A metastable first stage costs one cycle at most
    // Stage two alone is read
    // Last stage of the synchroniser marks sleep; its depth is the entry
    // and wake latency, so both delays come out the same
    assign asleep = s_q.sync[`SBC_SLEEP_ENTRY_CYC-1]; // [R8] [R10] [R7]

    // Next state
    // Per edge: synchroniser, late write, decode, access
    // Asleep, only the synchroniser moves; read drive and access strobe clear
    // Continue with no open burst does nothing
    // Write aborts still step the counter
    // Order pin is assumed static
    always_comb begin
        s_d      = s_q;
        nxt_idx  = s_q.idx + 2'd1;   // Two-bit wrap gives four accesses [R3] [R15]
        low_bits = 2'b00;
        acc      = s_q.base;
        do_acc   = 1'b0;


        // First stage is read only by the second stage
        s_d.sync = {s_q.sync[`SBC_SLEEP_ENTRY_CYC-2:0], pins.sleep_req}; // [R6] [R7]

        s_d.acc_vld = 1'b0;

        if (asleep) begin
            // Internal state frozen, read drive and access strobe dropped [R9] [R11] [R12]
            // Only the synchroniser moves while asleep
            s_d.dq_oe = 1'b0;
        end else begin
            s_d.dq_oe = 1'b0;

            // Single late write: data arrives one edge after the address
            if (s_q.wr_pend) begin
                s_d.mem[s_q.wr_addr] = pins.dq;
                s_d.wr_pend          = 1'b0;
            end

            // Control pin decode
            if (!pins.load_advance_ctl) begin
                // Load cycle
                if (!pins.ce_n) begin
                    // New burst series, index back to zero
                    s_d.base = pins.addr;                   // [R2] [R16]
                    s_d.idx  = 2'd0;
                    s_d.op   = pins.we_n ? SBC_OP_READ : SBC_OP_WRITE;
                    acc      = pins.addr;
                    do_acc   = 1'b1;
                end else begin
                    // Deselect ends the burst
                    // A later continue finds no burst
                    s_d.op = SBC_OP_NONE;
                end

            end else if (s_q.op != SBC_OP_NONE) begin
                // Continue cycle steps the counter whatever follows [R17] [R1]
                s_d.idx = nxt_idx;                          // [R17]
                // Linear adds, interleaved XORs; two bits
                // wrap, so the fifth access reuses the start
                // Order pin is sampled live; changing it mid-burst is undefined
                if (pins.burst_order_sel) begin
                    low_bits = s_q.base[1:0] ^ nxt_idx;     // [R5] [R18]
                end else begin
                    low_bits = s_q.base[1:0] + nxt_idx;     // [R4]
                end

                acc    = {s_q.base[`SBC_AW-1:2], low_bits}; // [R1] [R15]
                do_acc = 1'b1;
            end

            // Access phase
            if (do_acc) begin
                s_d.acc_addr = acc;
                s_d.acc_vld  = 1'b1;

                // Read: data stands one cycle
                if (s_d.op == SBC_OP_READ) begin
                    // Forward a write that lands this very edge
                    if (s_q.wr_pend && (s_q.wr_addr == acc)) begin
                        s_d.dq_o = pins.dq;
                    end else begin
                        s_d.dq_o = s_q.mem[acc];
                    end
                    s_d.dq_oe = 1'b1;

                end else if (!pins.bw_n) begin
                    // Write; byte write high is an abort
                    s_d.wr_pend = 1'b1;
                    s_d.wr_addr = acc;
                end
            end
        end
    end

    // State register
    // Async clear to constants only
    // Reset leaves it awake and idle
    // Sleep pin enters through the record's synchroniser
    // No clock enable: every edge counts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            // Every field moves together
            s_q <= s_d;
        end
    end

    // OE pin gates read drive live,
    // so the controller may cut the bus
    // Output enable acts without the clock; sleep releases the bus [R11]
    assign pins.dev_dq_oe  = s_q.dq_oe & ~pins.oe_n & ~asleep;

    assign pins.dev_dq_o   = s_q.dq_o;

    assign dev_sleeping    = asleep;

    assign dev_access_addr = s_q.acc_addr;

    assign dev_access_vld  = s_q.acc_vld;

    // Limitation: order pin read on each continue
    // Limitation: one byte lane, no parity
    // Limitation: aborts leave memory untouched
    // Limitation: no clock enable or stall
    // Limitation: OE high reads still step the counter

endmodule

// File: verif/sbc_properties.sv
// Purpose: Concurrent checks on the pins between controller and device
// Assumes: One clock domain; instantiated beside the interface
// Notes:   Helper state rebuilds the burst address from the pins and dev_sleeping
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_properties
    import sbc_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic [`SBC_AW-1:0] addr,
    input wire logic               load_advance_ctl,
    input wire logic               ce_n,
    input wire logic               we_n,
    input wire logic               ctl_dq_oe,
    input wire logic               dev_dq_oe,
    input wire logic               burst_order_sel,
    input wire logic               sleep_req,
    input wire logic               dev_sleeping,
    input wire logic [`SBC_AW-1:0] dev_access_addr,
    input wire logic               dev_access_vld
);
    // Mirror of the burst counter
    typedef struct packed {
        logic               act;  // Burst open
        logic [1:0]         idx;  // Access index, wraps by width
        logic [`SBC_AW-1:0] base; // Loaded start address
        logic [`SBC_AW-1:0] exp;  // Address of the latest access
    } sbc_chk_state_t;
    sbc_chk_state_t st_q;         // Registered mirror
    sbc_chk_state_t st_d;         // Next mirror

    // Asleep the pins are ignored, so the mirror freezes too
    always_comb begin
        st_d = st_q;
        if (!dev_sleeping && !load_advance_ctl && !ce_n) begin
            st_d.act  = 1'b1;
            st_d.idx  = 2'd0;
            st_d.base = addr;
            st_d.exp  = addr;
        end else if (!dev_sleeping && !load_advance_ctl) begin
            st_d.act = 1'b0;
        end else if (!dev_sleeping && st_q.act) begin
            st_d.idx = st_q.idx + 2'd1;
            st_d.exp = {st_q.base[`SBC_AW-1:2], burst_order_sel ?
                        st_q.base[1:0] ^ st_d.idx : st_q.base[1:0] + st_d.idx};
        end
    end

    // Mirror register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Two-cycle entry and exit shapes
    sequence s_enter;
        !dev_sleeping ##1 dev_sleeping;
    endsequence
    sequence s_leave;
        dev_sleeping ##1 !dev_sleeping;
    endsequence

    AST_ADDR_SEQ:
        assert property (dev_access_vld |-> dev_access_addr == st_q.exp)
        else $error("device access address off the burst sequence");
    AST_LOAD_TAKEN:
        assert property (!load_advance_ctl && !ce_n && !dev_sleeping |=> dev_access_vld)
        else $error("load cycle produced no access");
    AST_STEP_TAKEN:
        assert property (load_advance_ctl && st_q.act && !dev_sleeping |=> dev_access_vld)
        else $error("continue cycle produced no access");
    AST_NO_ACC_ASLEEP:
        assert property ($past(dev_sleeping) |-> !dev_access_vld)
        else $error("access while asleep");
    AST_SLEEP_ENTRY:
        assert property ($rose(sleep_req) ##1 sleep_req |-> s_enter)
        else $error("sleep entry not two cycles after request");
    AST_SLEEP_EXIT:
        assert property ($fell(sleep_req) ##1 !sleep_req |-> s_leave)
        else $error("wake not two cycles after release");
    AST_SLEEP_HOLD:
        assert property ($past(sleep_req, 2) && $past(sleep_req) |-> dev_sleeping)
        else $error("sleep left while request held");
    AST_HIZ_ASLEEP:
        assert property (dev_sleeping |-> !dev_dq_oe)
        else $error("device drives data while asleep");
    AST_IDLE_SLEEP:
        assert property ($rose(sleep_req) |-> ce_n && $past(ce_n) && !ctl_dq_oe)
        else $error("sleep raised with an operation pending");
    AST_RECOV_NOWR:
        assert property ($fell(sleep_req) |-> (ce_n || we_n) [*2])
        else $error("write issued during recovery");
endmodule

// File: verif/sram_burst_counter_sleep_ctl_tb.sv
// Purpose: Self-checking bench driving the controller over Avalon-MM
// Assumes: Device and controller face each other through the interface
// Notes:   Burst order is changed only between bursts, never mid-burst
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sram_burst_counter_sleep_ctl_tb;
    logic               core_clk;        // System clock
    logic               rst_n;           // Async reset, active low
    logic [4:0]         avs_address;     // Byte address
    logic               avs_read;        // Read request
    logic               avs_write;       // Write request
    logic [31:0]        avs_writedata;   // Write data
    logic [31:0]        avs_readdata;    // Read data
    logic               avs_waitrequest; // Slave stall
    logic               dev_sleeping;    // Device asleep
    logic [`SBC_AW-1:0] dev_access_addr; // Last access address
    logic               dev_access_vld;  // Access pulse
    logic [31:0]        q;               // Read result
    logic [31:0]        dat;             // Burst data
    logic [5:0]         base;            // Burst start
    int                 failures;        // Mismatch count
    int                 n_compared;      // Comparison count

    sbc_if pins_if();

    sbc_dev i_sbc_dev (.core_clk(core_clk), .rst_n(rst_n), .pins(pins_if.dev),
        .dev_sleeping(dev_sleeping), .dev_access_addr(dev_access_addr),
        .dev_access_vld(dev_access_vld));
    sbc_ctl i_sbc_ctl (.core_clk(core_clk), .rst_n(rst_n), .pins(pins_if.ctl),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    sbc_properties u_props (.core_clk(core_clk), .rst_n(rst_n), .addr(pins_if.addr),
        .load_advance_ctl(pins_if.load_advance_ctl), .ce_n(pins_if.ce_n), .we_n(pins_if.we_n),
        .ctl_dq_oe(pins_if.ctl_dq_oe), .dev_dq_oe(pins_if.dev_dq_oe),
        .burst_order_sel(pins_if.burst_order_sel), .sleep_req(pins_if.sleep_req),
        .dev_sleeping(dev_sleeping), .dev_access_addr(dev_access_addr),
        .dev_access_vld(dev_access_vld));

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Closing report
    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One Avalon access; request held until waitrequest is seen low
    task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                           output logic [31:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do begin
            @(negedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            failures++;
            print_verdict();
        end
        @(posedge core_clk);
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Register write, result dropped
    task automatic wr(input logic [2:0] off, input logic [31:0] d);
        logic [31:0] r;
        av_xfer(1'b1, {off, 2'b00}, d, r);
    endtask

    // Register read
    task automatic rd(input logic [2:0] off, output logic [31:0] r);
        av_xfer(1'b0, {off, 2'b00}, 32'h0, r);
    endtask

    // Start a burst and poll busy with a bound
    task automatic burst(input logic w, input logic [5:0] a, input logic [1:0] len_m1,
                         input logic [31:0] d);
        logic [31:0] s;
        int n;
        n = 0;
        wr(`SBC_OFF_ADDR, {26'h0, a});
        if (w) begin
            wr(`SBC_OFF_WDATA, d);
        end
        wr(`SBC_OFF_CMD, {29'h0, len_m1, w});
        do begin
            rd(`SBC_OFF_STATUS, s);
            n++;
        end while (s[0] !== 1'b0 && n < 50);
        if (n >= 50) begin
            failures++;
            print_verdict();
        end
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        failures = 0;
        n_compared = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped slot
        rd(`SBC_OFF_CTRL, q);
        check(q, 32'h0);
        rd(`SBC_OFF_STATUS, q);
        check(q, 32'h0);
        wr(3'h7, 32'hffff_ffff);
        rd(3'h7, q);
        check(q, 32'h0);
        // Four-beat write in each order, read back one address at a time
        for (int o = 0; o < 2; o++) begin
            base = o ? 6'h0b : 6'h05;
            dat = o ? 32'hd4c3_b2a1 : 32'h4433_2211;
            wr(`SBC_OFF_CTRL, {30'h0, o[0], 1'b0});
            burst(1'b1, base, 2'd3, dat);
            for (int k = 0; k < 4; k++) begin
                burst(1'b0, {base[5:2], o ? base[1:0] ^ k[1:0] : base[1:0] + k[1:0]},
                      2'd0, 32'h0);
                rd(`SBC_OFF_RDATA, q);
                check({24'h0, q[7:0]}, {24'h0, dat[8*k +: 8]});
            end
        end
        // Sleep held for a while, then woken
        wr(`SBC_OFF_CTRL, 32'h3);
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        check({31'h0, dev_sleeping}, 32'h1);
        rd(`SBC_OFF_STATUS, q);
        check({30'h0, q[1:0]}, 32'h2);
        wr(`SBC_OFF_CTRL, 32'h2);
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        check({31'h0, dev_sleeping}, 32'h0);
        // Contents kept across sleep, whole interleaved burst back
        burst(1'b0, 6'h0b, 2'd3, 32'h0);
        rd(`SBC_OFF_RDATA, q);
        check(q, 32'hd4c3_b2a1);
        print_verdict();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        print_verdict();
    end
endmodule
